// File: hw/pd_consts.vh
`ifndef PD_CONSTS_VH
`define PD_CONSTS_VH
`define A_MR0 4'h0
`define A_MR1 4'h1
`define A_MR2 4'h2
`define A_CTRL 4'h3
`define A_TPD 4'h4
`define A_TCKE_XP 4'h5
`define A_TXPDLL 4'h6
`define A_TPDMAX 4'h7
`define A_STATUS 4'h8
`define A_VIOL 4'h9
`define A_REFCNT 4'hA
`define MR0_PPD_FAST 12
`define MR0_WR_HI 11
`define MR0_WR_LO 9
`define MR1_RTT_B2 9
`define MR1_RTT_B1 6
`define MR1_RTT_B0 2
`define MR2_RTTWR_HI 10
`define MR2_RTTWR_LO 9
`define CTRL_DLL_DIS 0
`define CTRL_SELF_REF 1
`define RST_TPD 8'h03
`define RST_TCKE 8'h03
`define RST_TXP 8'h03
`define RST_TXPDLL 8'h0A
`define RST_TPDMAX 16'h015F
`define CMD_READ 4'h5
`define CMD_REF 4'h1
`define CMD_NOP 4'h7
`define NVIOL 6
`endif

// File: hw/pd_timer.v
`default_nettype none
module pd_timer (
   input wire core_clk,
   input wire rst_n,
   input wire load,
   input wire tick,
   input wire [7:0] value,
   output wire done
);
   reg [7:0] cnt_r;

   always @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
         cnt_r <= 8'h00;
      else if (load)
         cnt_r <= value;
      else if (tick && cnt_r != 8'h00)
         cnt_r <= cnt_r - 8'h01;
   end

   assign done = (cnt_r == 8'h00);
endmodule
`default_nettype wire

// File: hw/sdram_powerdown_reset_odt_ctrl.v
// Our own choices: the placing of the registers and the address-and-strobe port.
`include "pd_consts.vh"
`default_nettype none
module sdram_powerdown_reset_odt_ctrl (
   input wire core_clk,
   input wire rst_n,
   input wire ck,
   input wire cke,
   input wire [3:0] cmd_pins,
   input wire odt,
   input wire bank_open,
   input wire cmd_busy,
   input wire write_burst,
   input wire [3:0] reg_addr,
   input wire [15:0] reg_wdata,
   input wire reg_wr,
   input wire reg_rd,
   output reg [15:0] reg_rdata,
   output wire dll_on,
   output wire act_pd,
   output wire pre_pd,
   output wire buf_off,
   output wire out_en_n,
   output reg rtt_nom_on,
   output reg rtt_wr_on,
   output wire odt_async,
   output wire [4:0] wr_cycles
);
   // ********************************************************
   // Decoding helpers
   // ********************************************************
   localparam ST_IDLE = 2'd0;
   localparam ST_PEND = 2'd1;
   localparam ST_APD = 2'd2;
   localparam ST_PPD = 2'd3;

   function is_nop;
      input [3:0] c;
      begin
         is_nop = c[3] | (c == `CMD_NOP);
      end
   endfunction

   function [4:0] wr_decode;
      input [2:0] f;
      begin
         case (f)
            3'd1: wr_decode = 5'd5;
            3'd2: wr_decode = 5'd6;
            3'd3: wr_decode = 5'd7;
            3'd4: wr_decode = 5'd8;
            3'd5: wr_decode = 5'd10;
            3'd6: wr_decode = 5'd12;
            3'd7: wr_decode = 5'd14;
            default: wr_decode = 5'd16;
         endcase
      end
   endfunction

   // ********************************************************
   // Pin synchronisers
   // ********************************************************
   // The CK pin is slow beside core_clk, so its edges are found by
   // sampling; every pin passes two flops before any logic looks at it.
   reg [6:0] sync1_r;
   reg [6:0] sync2_r;
   reg ck_prev_r;
   wire ck_s;
   wire cke_s;
   wire [3:0] cmd_s;
   wire odt_s;
   wire ck_rise;

   always @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         sync1_r <= 7'h00;
         sync2_r <= 7'h00;
         ck_prev_r <= 1'b0;
      end
      else
      begin
         sync1_r <= {ck, cke, cmd_pins, odt};
         sync2_r <= sync1_r;
         ck_prev_r <= sync2_r[6];
      end
   end

   assign ck_s = sync2_r[6];
   assign cke_s = sync2_r[5];
   assign cmd_s = sync2_r[4:1];
   assign odt_s = sync2_r[0];
   assign ck_rise = ck_s & ~ck_prev_r;

   // ********************************************************
   // Register file
   // ********************************************************
   reg [12:0] mr0_r;
   reg [2:0] rtt_nom_r;
   reg [1:0] rtt_wr_r;
   reg [1:0] ctrl_r;
   reg [7:0] tpd_r;
   reg [7:0] tcke_r;
   reg [7:0] txp_r;
   reg [7:0] txpdll_r;
   reg [15:0] tpdmax_r;
   reg [`NVIOL-1:0] viol_r;
   reg [`NVIOL-1:0] viol_set;
   reg [15:0] refcnt_r;
   reg [1:0] state_r;
   reg dll_r;
   reg syncing_r;
   wire wr_hit;

   assign wr_hit = reg_wr & (reg_addr == `A_VIOL);

   always @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         mr0_r <= 13'h0000;
         rtt_nom_r <= 3'h0;
         rtt_wr_r <= 2'h0;
         ctrl_r <= 2'h0;
         tpd_r <= `RST_TPD;
         tcke_r <= `RST_TCKE;
         txp_r <= `RST_TXP;
         txpdll_r <= `RST_TXPDLL;
         tpdmax_r <= `RST_TPDMAX;
      end
      else if (reg_wr)
      begin
         case (reg_addr)
            `A_MR0: mr0_r <= reg_wdata[12:0];
            `A_MR1: rtt_nom_r <= {reg_wdata[`MR1_RTT_B2],
                                  reg_wdata[`MR1_RTT_B1],
                                  reg_wdata[`MR1_RTT_B0]};
            `A_MR2: rtt_wr_r <= reg_wdata[`MR2_RTTWR_HI:`MR2_RTTWR_LO];
            `A_CTRL: ctrl_r <= reg_wdata[1:0];
            `A_TPD: tpd_r <= reg_wdata[7:0];
            `A_TCKE_XP:
            begin
               tcke_r <= reg_wdata[7:0];
               txp_r <= reg_wdata[15:8];
            end
            `A_TXPDLL: txpdll_r <= reg_wdata[7:0];
            `A_TPDMAX: tpdmax_r <= reg_wdata;
            default: ;
         endcase
      end
   end

   // A violation caught in the same cycle as its clear stays set.
   always @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
         viol_r <= {`NVIOL{1'b0}};
      else
         viol_r <= (viol_r & ~({`NVIOL{wr_hit}} & reg_wdata[`NVIOL-1:0]))
                   | viol_set;
   end

   // The refresh counter is deliberately kept out of the reset tree;
   // software seeds it once after power-up.
   always @(posedge core_clk)
   begin
      if (reg_wr && reg_addr == `A_REFCNT)
         refcnt_r <= reg_wdata;
      else if (ck_rise && cke_s && cmd_s == `CMD_REF)
         refcnt_r <= refcnt_r + 16'h0001;
   end

   always @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
         reg_rdata <= 16'h0000;
      else if (reg_rd)
      begin
         case (reg_addr)
            `A_MR0: reg_rdata <= {3'b000, mr0_r};
            `A_MR1: reg_rdata <= {6'h00, rtt_nom_r[2], 2'b00,
                                  rtt_nom_r[1], 3'b000, rtt_nom_r[0], 2'b00};
            `A_MR2: reg_rdata <= {5'h00, rtt_wr_r, 9'h000};
            `A_CTRL: reg_rdata <= {14'h0000, ctrl_r};
            `A_TPD: reg_rdata <= {8'h00, tpd_r};
            `A_TCKE_XP: reg_rdata <= {txp_r, tcke_r};
            `A_TXPDLL: reg_rdata <= {8'h00, txpdll_r};
            `A_TPDMAX: reg_rdata <= tpdmax_r;
            `A_STATUS: reg_rdata <= {6'h00, wr_cycles, odt_async,
                                     syncing_r, dll_on, state_r};
            `A_VIOL: reg_rdata <= {10'h000, viol_r};
            `A_REFCNT: reg_rdata <= refcnt_r;
            default: reg_rdata <= 16'h0000;
         endcase
      end
      else
         reg_rdata <= 16'h0000;
   end

   assign wr_cycles = wr_decode(mr0_r[`MR0_WR_HI:`MR0_WR_LO]);

   // ********************************************************
   // Exit and entry timers
   // ********************************************************
   // Timer 0 minimum power-down, 1 CKE high, 2 exit, 3 DLL-lock exit.
   wire [3:0] t_load;
   wire [3:0] t_done;
   wire [31:0] t_value;
   wire in_pd;
   wire entry_ev;
   wire exit_ev;

   assign t_value = {txpdll_r, txp_r, tcke_r, tpd_r};
   assign t_load = {exit_ev, exit_ev, exit_ev, entry_ev};

   genvar gi;
   generate
      for (gi = 0; gi < 4; gi = gi + 1)
      begin : g_tmr
         pd_timer u_tmr (
            .core_clk(core_clk),
            .rst_n(rst_n),
            .load(t_load[gi]),
            .tick(ck_rise),
            .value(t_value[gi*8 +: 8]),
            .done(t_done[gi])
         );
      end
   endgenerate

   // ********************************************************
   // Power-down state machine
   // ********************************************************
   reg cke_last_r;
   reg slow_exit_r;
   reg [15:0] pd_cnt_r;
   reg [1:0] state_nxt;
   wire ppd_slow;

   assign in_pd = (state_r != ST_IDLE);
   assign entry_ev = ck_rise & (state_r == ST_IDLE) & cke_last_r & ~cke_s
                     & is_nop(cmd_s);
   assign exit_ev = ck_rise & in_pd & cke_s & is_nop(cmd_s);
   assign ppd_slow = ~mr0_r[`MR0_PPD_FAST];

   always @*
   begin
      state_nxt = state_r;
      case (state_r)
         ST_IDLE:
            if (entry_ev)
            begin
               if (cmd_busy)
                  state_nxt = ST_PEND;
               else if (bank_open)
                  state_nxt = ST_APD;
               else
                  state_nxt = ST_PPD;
            end
         ST_PEND:
            if (exit_ev)
               state_nxt = ST_IDLE;
            else if (!cmd_busy)
               state_nxt = bank_open ? ST_APD : ST_PPD;
         ST_APD, ST_PPD:
            if (exit_ev)
               state_nxt = ST_IDLE;
         default: state_nxt = ST_IDLE;
      endcase
   end

   // Reset clears the machine whenever it falls, even in power-down.
   always @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         state_r <= ST_IDLE;
         cke_last_r <= 1'b0;
         dll_r <= 1'b1;
         syncing_r <= 1'b0;
         slow_exit_r <= 1'b0;
         pd_cnt_r <= 16'h0000;
      end
      else
      begin
         state_r <= state_nxt;
         if (ck_rise)
            cke_last_r <= cke_s;
         if (state_nxt == ST_PPD && state_r != ST_PPD)
            dll_r <= ~ppd_slow;
         else if (state_nxt == ST_APD)
            dll_r <= 1'b1;
         else if (exit_ev)
            dll_r <= 1'b1;
         if (exit_ev)
         begin
            slow_exit_r <= (state_r == ST_PPD) & ~dll_r;
            syncing_r <= (state_r == ST_PPD) & ~dll_r;
         end
         else if (t_done[3])
            syncing_r <= 1'b0;
         if (!in_pd)
            pd_cnt_r <= 16'h0000;
         else if (ck_rise && pd_cnt_r != 16'hFFFF)
            pd_cnt_r <= pd_cnt_r + 16'h0001;
      end
   end

   // ********************************************************
   // Timing checks on the controller
   // ********************************************************
   // Checks only flag; the device keeps operating so a log shows
   // every slip instead of hiding later ones.
   always @*
   begin
      viol_set = {`NVIOL{1'b0}};
      viol_set[0] = exit_ev & ~t_done[0];
      viol_set[1] = ck_rise & ~in_pd & ~cke_s & ~t_done[1];
      viol_set[2] = ck_rise & ~in_pd & cke_s & ~is_nop(cmd_s)
                    & ~t_done[2];
      viol_set[3] = (ck_rise & ~in_pd & slow_exit_r & ~t_done[3]
                     & ((cmd_s == `CMD_READ) | odt_s))
                    | (entry_ev & ~t_done[3]);
      viol_set[4] = in_pd & (pd_cnt_r > tpdmax_r);
      viol_set[5] = ctrl_r[`CTRL_SELF_REF] & odt_s;
   end

   // ********************************************************
   // Termination control
   // ********************************************************
   reg odt_q_r;
   wire nom_en;
   wire wr_en;
   wire term_ok;
   wire odt_eff;

   assign nom_en = (rtt_nom_r != 3'd0) & (rtt_nom_r < 3'd6);
   assign wr_en = (rtt_wr_r != 2'd0);
   assign term_ok = ~ctrl_r[`CTRL_DLL_DIS]
                    & ~ctrl_r[`CTRL_SELF_REF]
                    & (nom_en | wr_en);
   assign odt_async = ((state_r == ST_PPD) & ~dll_r) | syncing_r;
   assign odt_eff = odt_async ? odt_s : odt_q_r;

   always @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         odt_q_r <= 1'b0;
         rtt_nom_on <= 1'b0;
         rtt_wr_on <= 1'b0;
      end
      else
      begin
         if (ck_rise)
            odt_q_r <= odt_s;
         rtt_nom_on <= term_ok & nom_en & odt_eff
                       & ~(wr_en & write_burst);
         rtt_wr_on <= term_ok & wr_en & write_burst & odt_eff;
      end
   end

   // ********************************************************
   // Buffer and DLL outputs
   // ********************************************************
   assign dll_on = dll_r & ~ctrl_r[`CTRL_DLL_DIS];
   assign act_pd = (state_r == ST_APD);
   assign pre_pd = (state_r == ST_PPD);
   assign buf_off = act_pd | pre_pd;
   assign out_en_n = buf_off | ~rst_n;
endmodule
`default_nettype wire

// File: testbench/pd_properties.sv
`include "pd_consts.vh"
`default_nettype none
module pd_properties (
   input wire logic core_clk,
   input wire logic rst_n,
   input wire logic cke,
   input wire logic [3:0] cmd_pins,
   input wire logic odt,
   input wire logic bank_open,
   input wire logic cmd_busy,
   input wire logic write_burst,
   input wire logic dll_on,
   input wire logic act_pd,
   input wire logic pre_pd,
   input wire logic buf_off,
   input wire logic out_en_n,
   input wire logic rtt_nom_on,
   input wire logic rtt_wr_on,
   input wire logic odt_async
);
   timeunit 1ns;
   timeprecision 100ps;
   logic [3:0] lo_cnt_r;
   // ********************
   // Helper logic
   // ********************
   // Entry is only legal after the sampled CKE has sat low for a while.
   always_ff @(posedge core_clk or negedge rst_n)
      if (!rst_n)
         lo_cnt_r <= 4'h0;
      else if (cke)
         lo_cnt_r <= 4'h0;
      else if (lo_cnt_r != 4'hF)
         lo_cnt_r <= lo_cnt_r + 4'h1;
   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (!rst_n);
   // ********************
   // Properties
   // ********************
   sequence s_link_idle;
      (cke && cmd_pins == `CMD_NOP)[*8] ##1 (cke && cmd_pins == `CMD_NOP)[*6];
   endsequence
   sequence s_odt_low;
      (!odt)[*8] ##1 (!odt)[*6];
   endsequence
   // Reset must be seen while it is low, so this one is never disabled.
   property p_reset_outs;
      @(posedge core_clk) disable iff (1'b0)
      !rst_n |-> out_en_n && !act_pd && !pre_pd && !rtt_nom_on && !rtt_wr_on;
   endproperty
   property p_act_dll;
      act_pd |-> dll_on;
   endproperty
   property p_async;
      pre_pd && !dll_on |-> odt_async;
   endproperty
   property p_bufs;
      $onehot0({act_pd, pre_pd}) && buf_off == (act_pd || pre_pd)
      && (!(act_pd || pre_pd) || out_en_n);
   endproperty
   property p_odt_off;
      s_odt_low |-> !rtt_nom_on && !rtt_wr_on;
   endproperty
   property p_wr_term;
      (!write_burst)[*2] |-> !rtt_wr_on;
   endproperty
   property p_exit;
      s_link_idle |-> !(act_pd || pre_pd);
   endproperty
   property p_entry;
      $rose(act_pd || pre_pd) |-> lo_cnt_r >= 4'h4 && !$past(cmd_busy);
   endproperty
   property p_bank_act;
      $rose(act_pd) |-> $past(bank_open);
   endproperty
   property p_bank_pre;
      $rose(pre_pd) |-> !$past(bank_open);
   endproperty
   a_reset_outs: assert property (p_reset_outs)
      else $error("outputs active during reset");
   a_act_dll: assert property (p_act_dll)
      else $error("dll off in active power-down");
   a_async: assert property (p_async)
      else $error("termination not asynchronous with dll off");
   a_bufs: assert property (p_bufs)
      else $error("buffer state disagrees with power-down state");
   a_odt_off: assert property (p_odt_off)
      else $error("termination on with odt low");
   a_wr_term: assert property (p_wr_term)
      else $error("write termination outside a write burst");
   a_exit: assert property (p_exit)
      else $error("power-down held with cke high and nop");
   a_entry: assert property (p_entry)
      else $error("power-down entered without cke low or while busy");
   a_bank_act: assert property (p_bank_act)
      else $error("active power-down with all banks closed");
   a_bank_pre: assert property (p_bank_pre)
      else $error("precharge power-down with a bank open");
endmodule
bind sdram_powerdown_reset_odt_ctrl pd_properties u_pd_properties (
   .core_clk, .rst_n, .cke, .cmd_pins, .odt, .bank_open, .cmd_busy,
   .write_burst, .dll_on, .act_pd, .pre_pd, .buf_off, .out_en_n,
   .rtt_nom_on, .rtt_wr_on, .odt_async
);
`default_nettype wire

// File: testbench/ddr_ctrl_model.sv
`include "pd_consts.vh"
`default_nettype none
module ddr_ctrl_model (
   input wire logic core_clk,
   input wire logic want_pd,
   input wire logic odt_req,
   input wire logic [3:0] cmd_req,
   output logic ck = 1'b0,
   output logic cke = 1'b1,
   output logic [3:0] cmd_pins = `CMD_NOP,
   output logic odt = 1'b0
);
   timeunit 1ns;
   timeprecision 100ps;
   int ph = 0;
   int hold = 0;
   // ********************
   // Link driver
   // ********************
   // Entry and exit carry NOP; the bench asks for other commands only
   // while CKE stands high, so entry and exit stay legal.
   // Controls move on the falling clock, far from the sampling edge.
   always @(posedge core_clk)
   begin
      ph <= (ph + 1) % 4;
      if (ph == 3)
         ck <= ~ck;
      if (ph == 3 && ck)
      begin
         odt <= odt_req;
         cmd_pins <= cmd_req;
         if (hold > 0)
            hold <= hold - 1;
         else if (cke == want_pd)
         begin
            cke <= !want_pd;
            hold <= 4;
         end
      end
   end
endmodule
`default_nettype wire

// File: testbench/sdram_powerdown_reset_odt_ctrl_bench.sv
`include "pd_consts.vh"
`default_nettype none
module sdram_powerdown_reset_odt_ctrl_bench;
   timeunit 1ns;
   timeprecision 100ps;
   logic core_clk, rst_n, bank_open, cmd_busy, write_burst, reg_wr, reg_rd;
   logic want_pd, odt_req, bank, fast;
   logic [3:0] reg_addr, cmd_req;
   logic [15:0] reg_wdata, d;
   logic [2:0] wrf;
   wire ck, cke, odt, dll_on, act_pd, pre_pd, buf_off, out_en_n;
   wire rtt_nom_on, rtt_wr_on, odt_async;
   wire [3:0] cmd_pins;
   wire [15:0] reg_rdata;
   wire [4:0] wr_cycles;
   wire any_pd = act_pd | pre_pd;
   int error_cnt = 0;
   int checks = 0;
   int i, seed;
   logic [3:0] ra [5] = '{`A_TPD, `A_TCKE_XP, `A_TXPDLL, `A_TPDMAX, 4'hF};
   logic [15:0] rv [5] = '{16'h0003, 16'h0303, 16'h000A, 16'h015F, 16'h0000};
   logic [2:0] nf [7] = '{3'h1, 3'h3, 3'h4, 3'h1, 3'h0, 3'h2, 3'h6};
   logic [1:0] cf [7] = '{2'h0, 2'h0, 2'h2, 2'h1, 2'h0, 2'h0, 2'h0};
   logic wf [7] = '{1'b0, 1'b1, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0};
   logic [4:0] wrt [8] = '{5'h10, 5'h05, 5'h06, 5'h07,
                           5'h08, 5'h0A, 5'h0C, 5'h0E};
   sdram_powerdown_reset_odt_ctrl u_sdram_powerdown_reset_odt_ctrl (
      .core_clk, .rst_n, .ck, .cke, .cmd_pins, .odt, .bank_open, .cmd_busy,
      .write_burst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
      .dll_on, .act_pd, .pre_pd, .buf_off, .out_en_n, .rtt_nom_on,
      .rtt_wr_on, .odt_async, .wr_cycles
   );
   ddr_ctrl_model u_ddr_ctrl_model (
      .core_clk, .want_pd, .odt_req, .cmd_req, .ck, .cke, .cmd_pins, .odt
   );
   // ********************
   // Tasks
   // ********************
   task automatic end_of_test();
      if (error_cnt == 0 && checks > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      checks++;
      if (seen !== exp)
      begin
         error_cnt++;
         $display("BAD %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic wr(input logic [3:0] a, input logic [15:0] v);
      @(posedge core_clk);
      reg_addr <= a;
      reg_wdata <= v;
      reg_wr <= 1'b1;
      @(posedge core_clk);
      reg_wr <= 1'b0;
   endtask
   task automatic rd(input logic [3:0] a);
      @(posedge core_clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge core_clk);
      reg_rd <= 1'b0;
      #1 d = reg_rdata;
   endtask
   // A hang in power-down entry or exit is cut short here.
   task automatic wait_pd(input logic v);
      int n;
      n = 0;
      while (any_pd !== v)
      begin
         @(posedge core_clk);
         n++;
         if (n > 400)
         begin
            error_cnt++;
            end_of_test();
         end
      end
   endtask
   initial
   begin
      core_clk = 1'b0;
      forever #12.5 core_clk = ~core_clk;
   end
   // ********************
   // Main sequence
   // ********************
   initial
   begin
      seed = 32'h4ca06ead;
      {rst_n, bank_open, cmd_busy, write_burst, reg_wr, reg_rd} = 6'h00;
      {want_pd, odt_req, reg_addr, reg_wdata} = 22'h00_0000;
      cmd_req = `CMD_NOP;
      repeat (20) @(posedge core_clk);
      rst_n <= 1'b1;
      wr(4'hF, 16'hFFFF);
      for (i = 0; i < 5; i++)
      begin
         rd(ra[i]);
         chk(d, rv[i]);
      end
      for (i = 0; i < 4; i++)
      begin
         bank = i[0];
         fast = i[1];
         wrf = 3'($random(seed));
         wr(`A_MR0, {3'h0, fast, wrf, 9'h000});
         bank_open <= bank;
         cmd_busy <= 1'b1;
         want_pd <= 1'b1;
         repeat (40) @(posedge core_clk);
         chk(any_pd, 1'b0);
         chk(wr_cycles, wrt[wrf]);
         cmd_busy <= 1'b0;
         wait_pd(1'b1);
         repeat (2) @(posedge core_clk);
         chk({act_pd, pre_pd, buf_off, out_en_n},
             {bank, !bank, 2'h3});
         chk({dll_on, odt_async},
             {bank | fast, !bank & !fast});
         rd(`A_STATUS);
         chk(d[9:0], {wrt[wrf], !bank & !fast, 1'b0, bank | fast,
             1'b1, !bank});
         want_pd <= 1'b0;
         wait_pd(1'b0);
         repeat (120) @(posedge core_clk);
      end
      rd(`A_VIOL);
      chk(d, 16'h0000);
      wr(`A_REFCNT, 16'h1234);
      want_pd <= 1'b1;
      wait_pd(1'b1);
      @(posedge core_clk);
      rst_n <= 1'b0;
      #1 chk({any_pd, out_en_n, rtt_nom_on, rtt_wr_on}, 4'h4);
      repeat (5) @(posedge core_clk);
      rst_n <= 1'b1;
      want_pd <= 1'b0;
      rd(`A_REFCNT);
      chk(d, 16'h1234);
      for (i = 0; i < 7; i++)
      begin
         wr(`A_MR1, {6'h00, nf[i][2], 2'h0, nf[i][1], 3'h0, nf[i][0], 2'h0});
         wr(`A_MR2, {6'h00, wf[i], 9'h000});
         wr(`A_CTRL, {14'h0000, cf[i]});
         odt_req <= 1'b1;
         write_burst <= wf[i];
         repeat (30) @(posedge core_clk);
         chk({rtt_nom_on, rtt_wr_on},
             {nf[i] != 0 && nf[i] < 6 && cf[i] == 0 && !wf[i],
              wf[i] && cf[i] == 0});
         odt_req <= 1'b0;
         write_burst <= 1'b0;
         repeat (30) @(posedge core_clk);
         chk({rtt_nom_on, rtt_wr_on}, 2'h0);
      end
      rd(`A_VIOL);
      chk(d, 16'h0020);
      wr(`A_VIOL, 16'h003F);
      cmd_req <= `CMD_REF;
      repeat (8) @(posedge core_clk);
      cmd_req <= `CMD_NOP;
      repeat (16) @(posedge core_clk);
      rd(`A_REFCNT);
      chk(d, 16'h1235);
      rd(`A_VIOL);
      chk(d, 16'h0000);
      end_of_test();
   end
endmodule
`default_nettype wire
